// File: hdl/rx_char_fifo.sv
// synchronous fifo holding received characters with their flags
`timescale 1ns/1ps
module rx_char_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 32
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;
    logic             push;
    logic             pop;

    // extra pointer bit tells full from empty
    assign out_valid = wr_ptr_r != rd_ptr_r;
    assign in_ready  = (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]) || (wr_ptr_r[AW] == rd_ptr_r[AW]);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
        end else if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_ptr_r <= '0;
        end else if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end
endmodule : rx_char_fifo

// File: hdl/uart_rx_data_error_status.sv
// serial receive path, data port and sticky receive error status
// How it works
// [RL1] data port low byte reads received character, writes queue a transmit character
// [RL2] frame error flag set when sampled stop bit is low
// [RL3] parity error flag set when received parity mismatches line control setting
// [RL4] break flag set when line stays low through a whole frame
// [RL5] one break pushes exactly one all-zero character
// [RL6] after break, wait for line high then a fresh valid start bit
// [RL7] overrun flag set when a character completes while storage is full
// [RL8] on overrun stored entries stay intact, only the shift register is lost
// [RL9] data port overrun flag clears when a character is next stored
// [RL10] any write to error-clear location zeroes all sticky bits
// [RL11] frame, parity and break flags travel with each stored character
// [RL12] software drains the receive storage after an overrun to continue
// [RL13] error-clear location is write-only and shares offset 0x04 with status
// [RL14] data port read pops the head entry with its flags
// [RL15] reserved bits read zero and ignore writes
`timescale 1ns/1ps
module uart_rx_data_error_status
    import uart_rx_pkg::*;
#(
    parameter int CLKS_PER_BIT = CLKS_PER_BIT_DEF,
    parameter int FIFO_DEPTH   = FIFO_DEPTH_DEF
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        rx_in,
    output logic      [7:0]  tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready
);
    localparam int CNT_W = $clog2(CLKS_PER_BIT) + 1;
    localparam logic [CNT_W-1:0] BIT_LAST  = CNT_W'(CLKS_PER_BIT - 1);
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(CLKS_PER_BIT / 2 - 1);

    function automatic logic expected_parity(input logic [7:0] d,
                                             input logic even, input logic stick);
        if (stick) begin
            expected_parity = ~even;
        end else begin
            expected_parity = even ? ^d : ~^d;
        end
    endfunction : expected_parity

    // bus side
    logic              req;
    logic              ack_r;
    logic              first;
    logic              acc;
    logic              sel_data;
    logic              sel_sts;
    logic              sel_lc;
    logic              tx_stall;
    logic              data_rd_valid_r;
    logic              pop;
    logic              err_clear;
    logic [31:0]       readdata_r;
    logic [7:0]        line_ctrl_r;
    logic [STS_W-1:0]  status_r;
    logic [STS_W-1:0]  status_set;
    logic [7:0]        tx_data_r;
    logic              tx_valid_r;

    // line side
    logic              rx_meta_r;
    logic              rx_s_r;
    rx_state_t         state_r;
    logic [CNT_W-1:0]  cnt_r;
    logic [2:0]        bit_idx_r;
    logic [7:0]        shift_r;
    logic              all_low_r;
    logic              par_err_r;
    logic              tick;
    logic              push_evt;
    logic              is_break;
    logic              push_frm;
    logic              push_par;
    logic [ENTRY_W-1:0] push_data;
    logic              ovr_pending_r;
    logic              ovr_evt;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [ENTRY_W-1:0] fifo_head;

    assign req      = read | write;
    assign sel_data = address[7:2] == DATA_PORT_OFS[7:2];
    assign sel_sts  = address[7:2] == STATUS_OFS[7:2];
    assign sel_lc   = address[7:2] == LINE_CTRL_OFS[7:2];
    // a data write waits while the previous character is still unclaimed
    assign tx_stall = write && sel_data && byteenable[0] && tx_valid_r && !tx_ready;
    assign first    = req && !ack_r;
    assign acc      = req && ack_r;
    assign waitrequest = first;
    assign readdata    = readdata_r;
    assign tx_data     = tx_data_r;
    assign tx_valid    = tx_valid_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= first && !tx_stall;
        end
    end

    // read data is latched in the waiting cycle so it stands at the accepting edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            readdata_r <= READDATA_RST;
        end else if (first && read) begin
            readdata_r <= 32'h0000_0000; // [RL15]
            if (sel_data) begin
                readdata_r[DATA_OVR_POS] <= ovr_pending_r;
                if (fifo_out_valid) begin
                    readdata_r[ENTRY_W-1:0] <= fifo_head; // [RL1] [RL11]
                end
            end else if (sel_sts) begin
                readdata_r[STS_W-1:0] <= status_r;
            end else if (sel_lc) begin
                readdata_r[7:0] <= line_ctrl_r;
            end
        end
    end

    // pop only an entry that was actually returned; a push landing meanwhile is kept
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_rd_valid_r <= 1'b0;
        end else begin
            data_rd_valid_r <= first && read && sel_data && fifo_out_valid;
        end
    end

    assign pop = acc && read && sel_data && data_rd_valid_r; // [RL14]

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            line_ctrl_r <= LINE_CTRL_RST;
        end else if (acc && write && sel_lc && byteenable[0]) begin
            line_ctrl_r <= writedata[7:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_data_r <= TX_DATA_RST;
        end else if (acc && write && sel_data && byteenable[0]) begin
            tx_data_r <= writedata[CHAR_W-1:0]; // [RL1]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_valid_r <= 1'b0;
        end else if (acc && write && sel_data && byteenable[0]) begin
            tx_valid_r <= 1'b1;
        end else if (tx_ready) begin
            tx_valid_r <= 1'b0;
        end
    end

    // sticky error bits; a new error in the clearing cycle survives
    assign err_clear  = acc && write && sel_sts; // [RL13]
    assign status_set = {ovr_evt, push_evt && is_break, push_evt && push_par,
                         push_evt && push_frm};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_r <= STATUS_RST;
        end else begin
            status_r <= (err_clear ? STATUS_RST : status_r) | status_set; // [RL10]
        end
    end

    // receive line synchroniser
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_meta_r <= 1'b1;
            rx_s_r    <= 1'b1;
        end else begin
            rx_meta_r <= rx_in;
            rx_s_r    <= rx_meta_r;
        end
    end

    assign tick     = cnt_r == '0;
    assign push_evt = state_r == RX_STOP && tick;
    // simplification: break is judged at the stop sample, mid stop bit
    assign is_break = all_low_r && !rx_s_r; // [RL4]
    assign push_frm = !is_break && !rx_s_r; // [RL2]
    assign push_par = !is_break && par_err_r; // [RL3]
    // a break stores one zero character and no other flags
    assign push_data = is_break ? ENTRY_W'(1) << ENT_BRK_POS // [RL5]
                                : {1'b0, push_par, push_frm, shift_r}; // [RL11]
    assign ovr_evt  = push_evt && !fifo_in_ready; // [RL7]

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= RX_IDLE;
        end else begin
            unique case (state_r)
                RX_IDLE: begin
                    if (!rx_s_r) begin
                        state_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (tick) begin
                        state_r <= rx_s_r ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (tick && bit_idx_r == 3'h7) begin
                        state_r <= line_ctrl_r[LC_PEN_POS] ? RX_PARITY : RX_STOP;
                    end
                end
                RX_PARITY: begin
                    if (tick) begin
                        state_r <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (tick) begin
                        state_r <= is_break ? RX_BREAK : RX_IDLE; // [RL5]
                    end
                end
                RX_BREAK: begin
                    if (rx_s_r) begin
                        state_r <= RX_IDLE; // [RL6]
                    end
                end
                default: begin
                    state_r <= RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (state_r == RX_IDLE) begin
            cnt_r <= HALF_LAST;
        end else if (tick) begin
            cnt_r <= BIT_LAST;
        end else begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bit_idx_r <= 3'h0;
        end else if (state_r != RX_DATA) begin
            bit_idx_r <= 3'h0;
        end else if (tick) begin
            bit_idx_r <= bit_idx_r + 3'h1;
        end
    end

    // only this register is lost on overrun, the stored entries stay valid
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shift_r <= 8'h00;
        end else if (state_r == RX_DATA && tick) begin
            shift_r <= {rx_s_r, shift_r[7:1]}; // [RL8]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            all_low_r <= 1'b0;
        end else if (state_r == RX_START) begin
            all_low_r <= 1'b1;
        end else if ((state_r == RX_DATA || state_r == RX_PARITY) && tick) begin
            all_low_r <= all_low_r && !rx_s_r; // [RL4]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            par_err_r <= 1'b0;
        end else if (state_r == RX_START) begin
            par_err_r <= 1'b0;
        end else if (state_r == RX_PARITY && tick) begin
            par_err_r <= rx_s_r != expected_parity(shift_r, line_ctrl_r[LC_EPS_POS],
                                                   line_ctrl_r[LC_SPS_POS]); // [RL3]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ovr_pending_r <= 1'b0;
        end else if (ovr_evt) begin
            ovr_pending_r <= 1'b1;
        end else if (push_evt) begin
            ovr_pending_r <= 1'b0; // [RL9]
        end
    end

    rx_char_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (push_evt),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_head)
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_break_seen;
        push_evt && is_break ##1 state_r == RX_BREAK;
    endsequence

    sequence s_data_read;
        first && read && sel_data && fifo_out_valid ##1 acc;
    endsequence

    AST_RD_DATA: assert property ( // [RL1]
        s_data_read |-> readdata[7:0] == $past(fifo_head[7:0]) && !waitrequest)
        else $error("data port read returned wrong character");
    AST_TX_LOAD: assert property ( // [RL1]
        acc && write && sel_data && byteenable[0] |=> tx_valid && tx_data == $past(writedata[7:0]))
        else $error("written character not queued");
    AST_FRAME: assert property ( // [RL2]
        push_evt && !rx_s_r && !all_low_r |=> status_r[STS_FRM_POS])
        else $error("frame error not flagged");
    AST_PARITY: assert property ( // [RL3]
        push_evt && par_err_r && !is_break |=> status_r[STS_PAR_POS])
        else $error("parity error not flagged");
    AST_BRK_FLAG: assert property ( // [RL4]
        s_break_seen |-> status_r[STS_BRK_POS])
        else $error("break not flagged");
    AST_BRK_ONE: assert property ( // [RL5]
        push_evt && is_break |-> push_data[CHAR_W-1:0] == 8'h00 && push_data[ENT_BRK_POS]
                                 && !push_data[ENT_FRM_POS] && !push_data[ENT_PAR_POS])
        else $error("break did not store one zero character");
    AST_BRK_HOLD: assert property ( // [RL6]
        state_r == RX_BREAK && !rx_s_r |=> state_r == RX_BREAK)
        else $error("receiver left break while line low");
    AST_OVR: assert property ( // [RL7]
        ovr_evt |=> ovr_pending_r && status_r[STS_OVR_POS])
        else $error("overrun not flagged");
    AST_OVR_CLR: assert property ( // [RL9]
        push_evt && fifo_in_ready |=> !ovr_pending_r)
        else $error("overrun flag not cleared on store");
    AST_ECR: assert property ( // [RL10]
        err_clear && !push_evt |=> status_r == STATUS_RST)
        else $error("error-clear write did not clear status");
    AST_RSV: assert property ( // [RL15]
        readdata[31:12] == 20'h0_0000)
        else $error("reserved bits not zero");
endmodule : uart_rx_data_error_status

// File: hdl/uart_rx_pkg.sv
// constants shared by the receive data and error status block
package uart_rx_pkg;
    // register byte offsets on the Avalon bus
    localparam logic [7:0] DATA_PORT_OFS  = 8'h00;
    localparam logic [7:0] STATUS_OFS     = 8'h04;
    localparam logic [7:0] LINE_CTRL_OFS  = 8'h1C;

    // serial_data_port fields
    localparam int CHAR_W     = 8;
    localparam int DATA_FRM_POS = 8;
    localparam int DATA_PAR_POS = 9;
    localparam int DATA_BRK_POS = 10;
    localparam int DATA_OVR_POS = 11;

    // receive_error_status fields
    localparam int STS_FRM_POS  = 0;
    localparam int STS_PAR_POS  = 1;
    localparam int STS_BRK_POS  = 2;
    localparam int STS_OVR_POS  = 3;
    localparam int STS_W        = 4;

    // receive_line_control fields
    localparam int LC_PEN_POS = 1;
    localparam int LC_EPS_POS = 2;
    localparam int LC_SPS_POS = 7;

    // stored entry: character plus frame, parity and break flags
    localparam int ENTRY_W    = 11;
    localparam int ENT_FRM_POS = 8;
    localparam int ENT_PAR_POS = 9;
    localparam int ENT_BRK_POS = 10;

    // values after reset
    localparam logic [7:0]      LINE_CTRL_RST = 8'h00;
    localparam logic [STS_W-1:0] STATUS_RST   = 4'h0;
    localparam logic [7:0]      TX_DATA_RST   = 8'h00;
    localparam logic [31:0]     READDATA_RST  = 32'h0000_0000;

    // buffering and timing
    localparam int FIFO_DEPTH_DEF   = 32;
    localparam int REF_CLK_HZ       = 20_000_000;
    localparam int BAUD_RATE_DEF    = 115_200;
    localparam int CLKS_PER_BIT_DEF = REF_CLK_HZ / BAUD_RATE_DEF;

    typedef enum logic [2:0] {
        RX_IDLE   = 3'h0,
        RX_START  = 3'h1,
        RX_DATA   = 3'h3,
        RX_PARITY = 3'h2,
        RX_STOP   = 3'h6,
        RX_BREAK  = 3'h7
    } rx_state_t;
endpackage : uart_rx_pkg

// File: test/serial_tx_model.sv
// remote serial transmitter driving the receive line
`timescale 1ns/1ps
module serial_tx_model #(
    parameter int CLKS_PER_BIT = 16
) (
    input  wire logic ref_clk,
    output logic      line
);
    // marking level between frames
    initial line = 1'b1;

    task automatic hold_bit(input logic v, input int clks);
        line <= v;
        repeat (clks) @(posedge ref_clk);
    endtask : hold_bit

    // start, eight data bits lsb first, optional parity, one stop
    task automatic send_char(input logic [7:0] ch, input logic par_en, input logic par_bit,
                             input logic stop_ok);
        @(posedge ref_clk);
        hold_bit(1'b0, CLKS_PER_BIT);
        for (int i = 0; i < 8; i++) hold_bit(ch[i], CLKS_PER_BIT);
        if (par_en) hold_bit(par_bit, CLKS_PER_BIT);
        if (stop_ok) hold_bit(1'b1, CLKS_PER_BIT);
        // short low stop so the line is high again before a start could be checked
        else hold_bit(1'b0, CLKS_PER_BIT * 3 / 4);
        hold_bit(1'b1, 2 * CLKS_PER_BIT);
    endtask : send_char

    // low far past one whole frame, then back to marking
    task automatic send_break(input int clks);
        @(posedge ref_clk);
        hold_bit(1'b0, clks);
        hold_bit(1'b1, 2 * CLKS_PER_BIT);
    endtask : send_break
endmodule : serial_tx_model

// File: test/uart_rx_data_error_status_tb.sv
// self-checking bench for the receive data port and error status
`timescale 1ns/1ps
module uart_rx_data_error_status_tb;
    import uart_rx_pkg::*;
    localparam int CPB = 16;
    logic        ref_clk, rst, read, write, tx_ready, rx_in, waitrequest, tx_valid, ovr;
    logic [7:0]  address, tx_data, lc, c;
    logic [3:0]  byteenable, err_sts;
    logic [31:0] writedata, readdata, rd;
    logic [10:0] q[$];
    logic [7:0]  txq[$];
    logic [7:0]  modes[5] = '{8'h00, 8'h02, 8'h06, 8'h82, 8'h86};
    int          error_cnt, samples_checked, seed, n;

    uart_rx_data_error_status #(.CLKS_PER_BIT(CPB), .FIFO_DEPTH(FIFO_DEPTH_DEF)) DUT (
        .ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .rx_in(rx_in), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready));
    serial_tx_model #(.CLKS_PER_BIT(CPB)) line_src (.ref_clk(ref_clk), .line(rx_in));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic test_done;
        $display("errors %0d comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_tx(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: sent %h expected %h", $time, got, exp);
        end
    endtask : chk_tx

    // one Avalon access; waitrequest and read data are sampled at the rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int k;
        @(posedge ref_clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        byteenable <= be;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 1000);
        if (waitrequest !== 1'b0) begin
            error_cnt++;
            $display("mismatch at %0t: bus answer missing", $time);
            test_done;
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, 4'h0);
        chk_reg(rd, exp);
    endtask : rd_chk

    // head entry with its flags, overrun is live
    task automatic rd_data;
        logic [10:0] e;
        e = (q.size() > 0) ? q.pop_front() : 11'h000;
        rd_chk(DATA_PORT_OFS, {20'h0_0000, ovr, e});
    endtask : rd_data

    function automatic logic par_of(input logic [7:0] ch);
        return lc[7] ? !lc[2] : (lc[2] ? ^ch : ~^ch);
    endfunction : par_of

    // send one character and update the model of storage and status
    task automatic rx(input logic pbad, input logic sok);
        logic [10:0] e;
        c = 8'($random(seed));
        if (!sok) c[0] = 1'b1;
        e = {1'b0, lc[1] & pbad, !sok, c};
        line_src.send_char(c, lc[1], par_of(c) ^ pbad, sok);
        if (q.size() < FIFO_DEPTH_DEF) begin
            q.push_back(e);
            ovr = 1'b0;
            err_sts[2:0] = err_sts[2:0] | e[10:8];
        end else begin
            ovr = 1'b1;
            err_sts[3] = 1'b1;
        end
    endtask : rx

    // far side of the transmit port stalls at random
    always @(posedge ref_clk) tx_ready <= 1'($random(seed));
    always @(negedge ref_clk) begin
        if (!rst && tx_valid === 1'b1 && tx_ready === 1'b1)
            chk_tx(tx_data, (txq.size() > 0) ? txq.pop_front() : 8'hxx);
    end

    initial begin
        seed = 32'h74cb_9f47;
        rst = 1'b1;
        {read, write, ovr} = '0;
        {address, byteenable, writedata, lc, err_sts} = '0;
        error_cnt = 0;
        samples_checked = 0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        chk_tx({7'h00, tx_valid}, 8'h00);
        rd_chk(DATA_PORT_OFS, 32'h0000_0000);
        rd_chk(STATUS_OFS, {28'h000_0000, STATUS_RST});
        rd_chk(LINE_CTRL_OFS, 32'h0000_0000);
        bus(1'b1, 8'h08, 32'hffff_ffff, 4'hf);
        rd_chk(8'h08, 32'h0000_0000);
        // the last write has lane 0 off and must not reach the transmitter
        for (int i = 0; i < 4; i++) begin
            c = 8'($random(seed));
            bus(1'b1, DATA_PORT_OFS, {24'($random(seed)), c}, (i == 3) ? 4'he : 4'hf);
            if (i != 3) txq.push_back(c);
        end
        foreach (modes[m]) begin
            lc = modes[m];
            bus(1'b1, LINE_CTRL_OFS, {24'h00_0000, lc}, 4'h1);
            rd_chk(LINE_CTRL_OFS, {24'h00_0000, lc});
            rx(1'b0, 1'b1);
            rx(1'b1, 1'b1);
            rd_data;
            rd_data;
        end
        lc = 8'h00;
        bus(1'b1, LINE_CTRL_OFS, 32'h0000_0000, 4'h1);
        rx(1'b0, 1'b0);
        rd_data;
        line_src.send_break(25 * CPB);
        q.push_back(11'h400);
        ovr = 1'b0;
        err_sts[2] = 1'b1;
        rx(1'b0, 1'b1);
        rd_data;
        rd_data;
        rd_data;
        rd_chk(STATUS_OFS, {28'h000_0000, err_sts});
        bus(1'b1, STATUS_OFS, 32'($random(seed)), 4'h0);
        err_sts = 4'h0;
        rd_chk(STATUS_OFS, 32'h0000_0000);
        // fill past capacity with nobody reading
        repeat (FIFO_DEPTH_DEF + 1) rx(1'b0, 1'b1);
        rd_chk(STATUS_OFS, {28'h000_0000, err_sts});
        rd_data;
        rx(1'b0, 1'b1);
        repeat (FIFO_DEPTH_DEF) rd_data;
        rd_data;
        bus(1'b1, STATUS_OFS, 32'hffff_ffff, 4'hf);
        rd_chk(STATUS_OFS, 32'h0000_0000);
        for (n = 0; n < 1000 && txq.size() > 0; n++) @(posedge ref_clk);
        chk_reg(txq.size(), 32'h0000_0000);
        test_done;
    end
endmodule : uart_rx_data_error_status_tb
